/* File: design/mise_core.sv */
// Execution core: accumulator, flags, option, file registers, return stack top, watchdog.
// Assumes issue is never raised while busy; sleep is left by reset or wake input.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module mise_core (
   input  wire logic        aclk,      // Clock
   input  wire logic        aresetn,   // Sync reset, active low
   mise_exec_if.sink        ex,        // Issued instructions
   input  wire logic        wake,      // Wake from sleep
   input  wire logic        fw_we,     // Bus write of file register
   input  wire logic [4:0]  fw_idx,    // Its index
   input  wire logic [7:0]  fw_data,   // Its data
   input  wire logic [10:0] stack_in,  // Stack top load value
   input  wire logic        stack_we,  // Stack top load
   output logic [7:0]       acc,       // Accumulator
   output logic [7:0]       option,    // Option register
   output logic [10:0]      program_counter, // Program counter
   output logic [10:0]      stack_top, // Return stack top
   output logic             carry,     // Carry flag
   output logic             half_carry_flag, // Half carry flag
   output logic             zero,      // Zero flag
   output logic             watchdog_expiry_flag, // Active low expiry flag
   output logic             power_down_flag, // Active low power-down flag
   output logic             pin_change_wake_flag, // Pin-change wake flag
   output logic             asleep,    // Oscillator halted
   output logic [7:0]       watchdog_counter, // Watchdog count
   output logic [7:0]       file_rd    // File register last written by bus
);
   mise_pkg::mise_op_e op;
   logic [7:0]  file_q [32];
   logic [7:0]  prescale;
   logic [4:0]  fidx;
   logic [7:0]  fval;
   logic [7:0]  next_res;
   logic [8:0]  diff;
   logic        dest_file;
   logic        go;
   logic [4:0]  rd_idx;

   mise_decode u_dec (.word(ex.word), .op(op));

   assign fidx      = ex.word[4:0];
   assign fval      = file_q[fidx];
   assign dest_file = ex.word[mise_pkg::DEST_BIT];
   assign diff      = {1'b0, fval} - {1'b0, acc};
   assign go        = ex.issue && !asleep;
   assign file_rd   = file_q[rd_idx];

   always_comb begin
      next_res = {fval[6:0], carry};
      if (op == mise_pkg::MISE_SUBF) begin
         next_res = diff[7:0];
      end
   end

   // Second cycle of a return discards the prefetched word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ex.busy <= 1'b0;
      end else begin
         ex.busy <= go && op == mise_pkg::MISE_RTLIT;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         program_counter <= mise_pkg::PCNT_RST;
      end else if (go && op == mise_pkg::MISE_RTLIT) begin
         program_counter <= stack_top;
      end else if (go) begin
         program_counter <= program_counter + 11'h001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stack_top <= mise_pkg::PCNT_RST;
      end else if (stack_we) begin
         stack_top <= stack_in;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc <= mise_pkg::ACC_RST;
      end else if (go) begin
         case (op)
            mise_pkg::MISE_LDLIT:  acc <= ex.word[7:0];
            mise_pkg::MISE_RTLIT:  acc <= ex.word[7:0];
            mise_pkg::MISE_ROTL,
            mise_pkg::MISE_SUBF:   if (!dest_file) acc <= next_res;
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         option <= mise_pkg::OPTION_RST;
      end else if (go && op == mise_pkg::MISE_OPTION) begin
         option <= acc;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 32; i++) file_q[i] <= 8'h00;
      end else if (go && dest_file
                   && (op == mise_pkg::MISE_ROTL || op == mise_pkg::MISE_SUBF)) begin
         file_q[fidx] <= next_res;
      end else if (fw_we) begin
         file_q[fw_idx] <= fw_data;
      end
   end

   // Read index follows file writes only, so later instruction words cannot move it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_idx <= 5'h00;
      end else if (fw_we) begin
         rd_idx <= fw_idx;
      end
   end

   // Only the rotate and subtract touch arithmetic flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         carry           <= 1'b0;
         half_carry_flag <= 1'b0;
         zero            <= 1'b0;
      end else if (go && op == mise_pkg::MISE_ROTL) begin
         carry <= fval[7];
      end else if (go && op == mise_pkg::MISE_SUBF) begin
         carry           <= !diff[8];
         half_carry_flag <= fval[3:0] >= acc[3:0];
         zero            <= diff[7:0] == 8'h00;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_expiry_flag <= 1'b1;
         power_down_flag      <= 1'b1;
         pin_change_wake_flag <= 1'b0;
      end else if (go && op == mise_pkg::MISE_SLEEP) begin
         watchdog_expiry_flag <= 1'b1;
         power_down_flag      <= 1'b0;
      end
   end

   // Watchdog runs off a prescaler; sleep clears both
   always_ff @(posedge aclk) begin
      if (!aresetn || (go && op == mise_pkg::MISE_SLEEP)) begin
         prescale         <= 8'h00;
         watchdog_counter <= mise_pkg::WDOG_CLR;
      end else if (!asleep) begin
         prescale <= prescale + 8'h01;
         if (prescale == 8'hff) watchdog_counter <= watchdog_counter + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         asleep <= 1'b0;
      end else if (go && op == mise_pkg::MISE_SLEEP) begin
         asleep <= 1'b1;
      end else if (wake) begin
         asleep <= 1'b0;
      end
   end

   chk_return_two_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
      go && op == mise_pkg::MISE_RTLIT |=> ex.busy ##1 !ex.busy)
      else $error("return did not take two cycles");
   chk_sleep_wdog_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      go && op == mise_pkg::MISE_SLEEP |=> watchdog_counter == 8'h00 && prescale == 8'h00)
      else $error("sleep left watchdog uncleared");
   chk_sleep_flags: assert property (@(posedge aclk) disable iff (!aresetn)
      go && op == mise_pkg::MISE_SLEEP |=> watchdog_expiry_flag && !power_down_flag
         && $stable(pin_change_wake_flag))
      else $error("sleep flags wrong");
   chk_sleep_enter: assert property (@(posedge aclk) disable iff (!aresetn)
      go && op == mise_pkg::MISE_SLEEP |=> asleep)
      else $error("sleep not entered");
endmodule
`default_nettype wire

/* File: design/mise_decode.sv */
// Combinational instruction decoder for the subset.
// Assumes a 12-bit word; anything outside the subset decodes as MISE_BAD.
`timescale 1ns/100ps
`default_nettype none
module mise_decode (
   input  wire logic [11:0]       word, // Instruction word
   output var mise_pkg::mise_op_e op    // Decoded operation
);
   always_comb begin
      if (word == mise_pkg::OP_NOP) begin
         op = mise_pkg::MISE_NOP;
      end else if (word == mise_pkg::OP_OPTION) begin
         op = mise_pkg::MISE_OPTION;
      end else if (word == mise_pkg::OP_SLEEP) begin
         op = mise_pkg::MISE_SLEEP;
      end else if (word[11:8] == mise_pkg::OP_LDLIT_HI) begin
         op = mise_pkg::MISE_LDLIT;
      end else if (word[11:8] == mise_pkg::OP_RTLIT_HI) begin
         op = mise_pkg::MISE_RTLIT;
      end else if (word[11:6] == mise_pkg::OP_ROTL_HI) begin
         op = mise_pkg::MISE_ROTL;
      end else if (word[11:6] == mise_pkg::OP_SUBF_HI) begin
         op = mise_pkg::MISE_SUBF;
      end else begin
         op = mise_pkg::MISE_BAD;
      end
   end
endmodule
`default_nettype wire

/* File: design/mise_exec_if.sv */
// Interface carrying one issued instruction from the bus slave to the core.
// Assumes one clock domain; the core accepts every issue in the same cycle, except while asleep.
`timescale 1ns/100ps
`default_nettype none
interface mise_exec_if;
   logic        issue;    // One-cycle pulse: execute word
   logic [11:0] word;     // Instruction word
   logic        busy;     // Second cycle of a return in progress
   modport src  (output issue, output word, input busy);
   modport sink (input issue, input word, output busy);
endinterface
`default_nettype wire

/* File: design/mise_pkg.sv */
// Package for the instruction subset execution block: opcodes, fields, reset values.
// Assumes 12-bit baseline instruction words and an 8-bit data path.
package mise_pkg;
   localparam logic [11:0] OP_NOP      = 12'h000;
   localparam logic [11:0] OP_OPTION   = 12'h002;
   localparam logic [11:0] OP_SLEEP    = 12'h003;
   localparam logic [3:0]  OP_LDLIT_HI = 4'hc;
   localparam logic [3:0]  OP_RTLIT_HI = 4'h8;
   localparam logic [5:0]  OP_ROTL_HI  = 6'h0d;
   localparam logic [5:0]  OP_SUBF_HI  = 6'h02;
   localparam int          DEST_BIT    = 5;
   localparam logic [7:0]  ACC_RST     = 8'h00;
   localparam logic [7:0]  OPTION_RST  = 8'hff;
   localparam logic [7:0]  WDOG_CLR    = 8'h00;
   localparam logic [10:0] PCNT_RST    = 11'h7ff;
   localparam logic [11:0] AXI_CTRL    = 12'h000;
   localparam logic [11:0] AXI_INSTR   = 12'h004;
   localparam logic [11:0] AXI_ACC     = 12'h008;
   localparam logic [11:0] AXI_STATUS  = 12'h00c;
   localparam logic [11:0] AXI_OPTION  = 12'h010;
   localparam logic [11:0] AXI_PCNT    = 12'h014;
   localparam logic [11:0] AXI_STACK   = 12'h018;
   localparam logic [11:0] AXI_FILE    = 12'h01c;
   localparam logic [11:0] AXI_WDOG    = 12'h020;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   typedef enum logic [2:0] {
      MISE_NOP, MISE_LDLIT, MISE_OPTION, MISE_RTLIT,
      MISE_SLEEP, MISE_ROTL, MISE_SUBF, MISE_BAD
   } mise_op_e;
endpackage

/* File: design/mise_top.sv */
// Top of the instruction subset executor with an AXI4-Lite register slave.
// Assumes one master with at most one write and one read outstanding.
// Function
// - Literal load sets accumulator, flags kept
// - Literal load unused bits encode as zero
// - Option load copies accumulator, flags kept
// - Return loads literal and stack top
// - Return takes two cycles, discards prefetch
// - Sleep clears watchdog and its prescaler
// - Sleep sets expiry, clears power-down flag
// - Sleep halts oscillator into low power
// - Rotate left through carry, carry only
// - Subtract accumulator from file, set flags
// - Target bit picks accumulator or file
`timescale 1ns/100ps
`default_nettype none
module mise_top (
   input  wire logic        aclk,          // Clock, 100 MHz
   input  wire logic        aresetn,       // Sync reset, active low
   input  wire logic [11:0] s_axi_awaddr,  // Write address
   input  wire logic        s_axi_awvalid, // Write address valid
   output logic             s_axi_awready, // Write address ready
   input  wire logic [31:0] s_axi_wdata,   // Write data
   input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
   input  wire logic        s_axi_wvalid,  // Write data valid
   output logic             s_axi_wready,  // Write data ready
   output logic [1:0]       s_axi_bresp,   // Write response
   output logic             s_axi_bvalid,  // Write response valid
   input  wire logic        s_axi_bready,  // Write response ready
   input  wire logic [11:0] s_axi_araddr,  // Read address
   input  wire logic        s_axi_arvalid, // Read address valid
   output logic             s_axi_arready, // Read address ready
   output logic [31:0]      s_axi_rdata,   // Read data
   output logic [1:0]       s_axi_rresp,   // Read response
   output logic             s_axi_rvalid,  // Read valid
   input  wire logic        s_axi_rready,  // Read ready
   output logic             sleeping       // Core asleep, oscillator halted
);
   mise_exec_if ex ();
   logic        aw_got, w_got;
   logic [11:0] aw_q;
   logic [31:0] w_q;
   logic [3:0]  s_q;
   logic        do_wr;
   logic [7:0]  acc, option, wdog, file_rd;
   logic [10:0] prog_cnt, stk_top;
   logic        c, hc, z, to_n, pdown_n, gpw, asleep;
   logic        fw_we, stack_we, wake;
   logic [4:0]  fidx;
   logic        issue_q;
   logic [11:0] word_q;

   mise_core u_core (
      .aclk(aclk), .aresetn(aresetn), .ex(ex), .wake(wake),
      .fw_we(fw_we), .fw_idx(fidx), .fw_data(w_q[7:0]),
      .stack_in(w_q[10:0]), .stack_we(stack_we),
      .acc(acc), .option(option), .program_counter(prog_cnt), .stack_top(stk_top),
      .carry(c), .half_carry_flag(hc), .zero(z),
      .watchdog_expiry_flag(to_n), .power_down_flag(pdown_n),
      .pin_change_wake_flag(gpw), .asleep(asleep),
      .watchdog_counter(wdog), .file_rd(file_rd)
   );

   assign ex.issue = issue_q;
   assign ex.word  = word_q;
   assign do_wr    = aw_got && w_got && !s_axi_bvalid;
   assign fw_we    = do_wr && aw_q == mise_pkg::AXI_FILE && s_q[0];
   assign stack_we = do_wr && aw_q == mise_pkg::AXI_STACK && s_q[0];
   assign wake     = do_wr && aw_q == mise_pkg::AXI_CTRL && s_q[0] && w_q[0];
   assign fidx     = w_q[12:8];

   // Address and data are taken in either order, then answered together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got  <= 1'b0;
         aw_q   <= 12'h000;
         w_q    <= 32'h0000_0000;
         s_q    <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= mise_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= s_axi_awaddr;
            aw_got <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= s_axi_wdata;
            s_q <= s_axi_wstrb;
            w_got <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            case (aw_q)
               mise_pkg::AXI_CTRL, mise_pkg::AXI_INSTR, mise_pkg::AXI_FILE,
               mise_pkg::AXI_STACK: s_axi_bresp <= mise_pkg::RESP_OKAY;
               default:             s_axi_bresp <= mise_pkg::RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Instruction writes are dropped while a return finishes its second cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         issue_q <= 1'b0;
         word_q  <= 12'h000;
      end else begin
         issue_q <= do_wr && aw_q == mise_pkg::AXI_INSTR && s_q[1:0] == 2'b11
                    && !ex.busy && !issue_q;
         if (do_wr && aw_q == mise_pkg::AXI_INSTR) word_q <= w_q[11:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= mise_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= mise_pkg::RESP_OKAY;
         case (s_axi_araddr)
            mise_pkg::AXI_CTRL:   s_axi_rdata <= {31'h0, asleep};
            mise_pkg::AXI_INSTR:  s_axi_rdata <= {20'h0, word_q};
            mise_pkg::AXI_ACC:    s_axi_rdata <= {24'h0, acc};
            mise_pkg::AXI_STATUS: s_axi_rdata <= {26'h0, gpw, to_n, pdown_n, z, hc, c};
            mise_pkg::AXI_OPTION: s_axi_rdata <= {24'h0, option};
            mise_pkg::AXI_PCNT:   s_axi_rdata <= {21'h0, prog_cnt};
            mise_pkg::AXI_STACK:  s_axi_rdata <= {21'h0, stk_top};
            mise_pkg::AXI_FILE:   s_axi_rdata <= {24'h0, file_rd};
            mise_pkg::AXI_WDOG:   s_axi_rdata <= {24'h0, wdog};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= mise_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleeping <= 1'b0;
      end else begin
         sleeping <= asleep;
      end
   end

   chk_literal_no_flags: assert property (@(posedge aclk) disable iff (!aresetn)
      issue_q && word_q[11:8] == mise_pkg::OP_LDLIT_HI && !asleep
      |=> acc == $past(word_q[7:0]) && $stable({c, hc, z}))
      else $error("literal load wrong");
   chk_option_load: assert property (@(posedge aclk) disable iff (!aresetn)
      issue_q && word_q == mise_pkg::OP_OPTION && !asleep
      |=> option == $past(acc) && $stable({c, hc, z}))
      else $error("option load wrong");
   chk_return_target: assert property (@(posedge aclk) disable iff (!aresetn)
      issue_q && word_q[11:8] == mise_pkg::OP_RTLIT_HI && !asleep
      |=> prog_cnt == $past(stk_top) && acc == $past(word_q[7:0]))
      else $error("return wrong");
   chk_nop_count_only: assert property (@(posedge aclk) disable iff (!aresetn)
      issue_q && word_q == mise_pkg::OP_NOP && !asleep
      |=> prog_cnt == $past(prog_cnt) + 11'h001 && $stable(acc))
      else $error("nop changed state");
endmodule
`default_nettype wire

/* File: verification/mise_top_test.sv */
// Self-checking testbench for the instruction subset executor, driven over AXI4-Lite.
// Assumes the register map and encodings of mise_pkg; the bench is the only bus master.
`timescale 1ns/100ps
`default_nettype none
module mise_top_test;
   logic        aclk;
   logic        aresetn;
   logic [11:0] awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [11:0] araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic        sleeping;
   int          mismatches;
   int          cmp_count;
   int          cycles;
   logic [31:0] count_before;

   localparam int TIMEOUT_CYCLES = 20000;
   localparam int WAIT_LIMIT     = 50;

   mise_top DUT (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (awaddr),
      .s_axi_awvalid (awvalid),
      .s_axi_awready (awready),
      .s_axi_wdata   (wdata),
      .s_axi_wstrb   (wstrb),
      .s_axi_wvalid  (wvalid),
      .s_axi_wready  (wready),
      .s_axi_bresp   (bresp),
      .s_axi_bvalid  (bvalid),
      .s_axi_bready  (bready),
      .s_axi_araddr  (araddr),
      .s_axi_arvalid (arvalid),
      .s_axi_arready (arready),
      .s_axi_rdata   (rdata),
      .s_axi_rresp   (rresp),
      .s_axi_rvalid  (rvalid),
      .s_axi_rready  (rready),
      .sleeping      (sleeping)
   );

   initial begin
      aclk = 1'b0;
   end
   always #5 aclk = ~aclk;

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Hang guard: the whole sequence needs a little under a thousand cycles
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT_CYCLES) begin
         mismatches = mismatches + 1;
         $display("ERROR t=%0t run timed out", $time);
         report_and_stop();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Address and data offered together; each is dropped at the edge it is taken
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      resp    = 2'bxx;
      while (n < WAIT_LIMIT) begin
         @(posedge aclk);
         n = n + 1;
         if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n >= WAIT_LIMIT) check(32'h0, 32'h1, "write response wait");
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      d       = 32'hx;
      resp    = 2'bxx;
      while (n < WAIT_LIMIT) begin
         @(posedge aclk);
         n = n + 1;
         if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (n >= WAIT_LIMIT) check(32'h0, 32'h1, "read data wait");
   endtask

   task automatic wr_ok(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      axi_write(a, d, s, r);
      check({30'h0, r}, {30'h0, mise_pkg::RESP_OKAY}, "write resp");
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      check({30'h0, r}, {30'h0, mise_pkg::RESP_OKAY}, "read resp");
      check(d, exp, what);
   endtask

   // Issue pulse lands in the same cycle as the response, result one cycle later
   task automatic exec(input logic [11:0] w);
      wr_ok(mise_pkg::AXI_INSTR, {20'h0, w}, 4'h3);
      repeat (2) @(posedge aclk);
   endtask

   task automatic set_file(input logic [4:0] idx, input logic [7:0] v);
      wr_ok(mise_pkg::AXI_FILE, {19'h0, idx, v}, 4'h3);
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      mismatches = 0;
      cmp_count = 0;
      cycles = 0;
      aresetn = 1'b0;
      awaddr = 12'h000;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 12'h000;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset state, then refused accesses to two unmapped words
      rd_chk(mise_pkg::AXI_ACC, 32'h0, "acc after reset");
      rd_chk(mise_pkg::AXI_OPTION, 32'hff, "option after reset");
      rd_chk(mise_pkg::AXI_PCNT, 32'h7ff, "counter after reset");
      rd_chk(mise_pkg::AXI_STATUS, 32'h18, "status after reset");
      axi_read(12'h040, d, r);
      check({30'h0, r}, {30'h0, mise_pkg::RESP_SLVERR}, "unmapped read resp");
      check(d, 32'h0, "unmapped read data");
      axi_write(12'h044, 32'h5, 4'hf, r);
      check({30'h0, r}, {30'h0, mise_pkg::RESP_SLVERR}, "unmapped write resp");
      // Literal load at both ends of the range
      exec(12'hcff);
      rd_chk(mise_pkg::AXI_ACC, 32'hff, "literal ff");
      exec(12'hc00);
      rd_chk(mise_pkg::AXI_ACC, 32'h0, "literal 00");
      rd_chk(mise_pkg::AXI_STATUS, 32'h18, "status after literal");
      exec(12'hc5a);
      exec(mise_pkg::OP_OPTION);
      rd_chk(mise_pkg::AXI_OPTION, 32'h5a, "option load");
      rd_chk(mise_pkg::AXI_STATUS, 32'h18, "status after option");
      axi_read(mise_pkg::AXI_PCNT, count_before, r);
      exec(mise_pkg::OP_NOP);
      rd_chk(mise_pkg::AXI_PCNT, {21'h0, count_before[10:0] + 11'h001}, "counter after nop");
      rd_chk(mise_pkg::AXI_ACC, 32'h5a, "acc after nop");
      rd_chk(mise_pkg::AXI_OPTION, 32'h5a, "option after nop");
      rd_chk(mise_pkg::AXI_STATUS, 32'h18, "status after nop");
      // Return with literal from a loaded stack top
      wr_ok(mise_pkg::AXI_STACK, 32'h123, 4'hf);
      exec(12'h8a5);
      rd_chk(mise_pkg::AXI_ACC, 32'ha5, "return literal");
      rd_chk(mise_pkg::AXI_PCNT, 32'h123, "return counter");
      rd_chk(mise_pkg::AXI_STATUS, 32'h18, "status after return");
      // Rotate left: bit 7 out to carry, old carry in at bit 0
      set_file(5'd3, 8'h81);
      exec(12'h363);
      rd_chk(mise_pkg::AXI_FILE, 32'h02, "rotate to file");
      rd_chk(mise_pkg::AXI_STATUS, 32'h19, "carry after rotate");
      exec(12'h343);
      rd_chk(mise_pkg::AXI_ACC, 32'h05, "rotate to acc");
      rd_chk(mise_pkg::AXI_FILE, 32'h02, "file kept on acc target");
      rd_chk(mise_pkg::AXI_STATUS, 32'h18, "carry cleared by rotate");
      // Subtract: nibble borrow, exact zero, full borrow
      exec(12'hc01);
      set_file(5'd4, 8'h10);
      exec(12'h084);
      rd_chk(mise_pkg::AXI_ACC, 32'h0f, "subtract to acc");
      rd_chk(mise_pkg::AXI_FILE, 32'h10, "file kept by subtract");
      rd_chk(mise_pkg::AXI_STATUS, 32'h19, "flags nibble borrow");
      exec(12'hc22);
      set_file(5'd5, 8'h22);
      exec(12'h0a5);
      rd_chk(mise_pkg::AXI_FILE, 32'h00, "subtract to zero");
      rd_chk(mise_pkg::AXI_ACC, 32'h22, "acc kept by subtract");
      rd_chk(mise_pkg::AXI_STATUS, 32'h1f, "flags zero result");
      exec(12'hc01);
      set_file(5'd6, 8'h00);
      exec(12'h0a6);
      rd_chk(mise_pkg::AXI_FILE, 32'hff, "subtract borrow");
      rd_chk(mise_pkg::AXI_STATUS, 32'h18, "flags full borrow");
      // Sleep after the watchdog has had time to count
      repeat (600) @(posedge aclk);
      exec(mise_pkg::OP_SLEEP);
      rd_chk(mise_pkg::AXI_WDOG, {24'h0, mise_pkg::WDOG_CLR}, "watchdog after sleep");
      rd_chk(mise_pkg::AXI_STATUS, 32'h10, "flags after sleep");
      rd_chk(mise_pkg::AXI_CTRL, 32'h1, "asleep bit");
      check({31'h0, sleeping}, 32'h1, "sleeping output");
      // A halted core must ignore instructions until woken
      exec(12'hc77);
      rd_chk(mise_pkg::AXI_ACC, 32'h01, "literal ignored asleep");
      wr_ok(mise_pkg::AXI_CTRL, 32'h1, 4'h1);
      rd_chk(mise_pkg::AXI_CTRL, 32'h0, "awake after wake");
      check({31'h0, sleeping}, 32'h0, "sleeping cleared");
      report_and_stop();
   end
endmodule
`default_nettype wire
